// ### design/monitor_limits_and_logic_states.sv
// Third monitor warning limits, calibration bytes, results and logic-state register
// Summary of operation
// - Third monitor above high warning limit sets warning bit 7; clears when below.
// - Third monitor below low warning limit sets warning bit 6; clears when above.
// - Warning limits are 16-bit, high byte at lower address, default zero.
// - Bytes 38h..5Fh are calibration storage, default zero, read and write.
// - Temperature: signed, integer byte at 60h, fraction byte at 61h.
// - Supply voltage unsigned 16-bit, high byte 62h, low byte 63h.
// - Three monitor results unsigned 16-bit, high byte first, at 64h/66h/68h.
// - Logic-state bit 7 reads the transmit-disable pin level.
// - Soft transmit-disable bit 6 at 1 turns the current-sink enable output off.
// - Bit 5 mirrors general input pin, bit 4 mirrors rate-select input pin.
// - Rate-select output is rate-select input OR soft rate-select bit 3.
// - Bit 2 reads the level of the transmit-fault output pin.
// - Bit 1 reads the level of the receive signal-loss pin.
// - Bit 0 reads 1 while supply is below power-on threshold, else 0.
// - After reset soft bits 6 and 3 are 0; other bits track their sources.
// - Only bits 6 and 3 of the logic-state register accept writes.
`timescale 1ns/1ps
`include "monitor_limits_consts.svh"
module monitor_limits_and_logic_states #(
  parameter int CAL_BYTES = `EXT_CAL_BYTES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output monitor_limits_pkg::byte_t rdata_o,
  input wire logic conv_valid_i,
  input wire logic [15:0] conv_temp_i,
  input wire logic [15:0] conv_vcc_i,
  input wire logic [15:0] conv_first_monitor_input_i,
  input wire logic [15:0] conv_second_monitor_input_i,
  input wire logic [15:0] conv_third_monitor_input_i,
  input wire logic tx_disable_pin_i,
  input wire logic general_input_pin_i,
  input wire logic rate_select_input_pin_i,
  input wire logic tx_fault_pin_i,
  input wire logic rx_signal_loss_pin_i,
  input wire logic below_power_on_analog_threshold_i,
  output logic rate_select_output_pin_o,
  output logic current_sink_enable_o,
  output monitor_limits_pkg::byte_t warn_flags_o
);
  import monitor_limits_pkg::*;

  initial begin
    if (CAL_BYTES != `EXT_CAL_BYTES) begin
      $error("CAL_BYTES must match the calibration window size");
    end
  end

  word_t hi_limit;
  word_t lo_limit;
  byte_t cal_mem [CAL_BYTES];
  word_t temp_res;
  word_t vcc_res;
  word_t first_monitor_input_res;
  word_t second_monitor_input_res;
  word_t third_monitor_input_res;
  logic soft_tx_disable;
  logic soft_rate_select;
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic tx_disable_pin_status;
  logic general_input_status;
  logic rate_select_input_status;
  logic tx_fault_status;
  logic rx_signal_loss_status;
  logic not_ready_flag;
  logic warn_hi;
  logic warn_lo;
  byte_t logic_states;
  byte_t next_rdata;
  logic [7:0] cal_idx;

  // Pins come from outside the clock domain
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta <= 6'h00;
      pin_sync <= 6'h00;
    end else begin
      pin_meta <= {tx_disable_pin_i, general_input_pin_i, rate_select_input_pin_i,
                   tx_fault_pin_i, rx_signal_loss_pin_i, below_power_on_analog_threshold_i};
      pin_sync <= pin_meta;
    end
  end

  assign tx_disable_pin_status = pin_sync[5];
  assign general_input_status = pin_sync[4];
  assign rate_select_input_status = pin_sync[3];
  assign tx_fault_status = pin_sync[2];
  assign rx_signal_loss_status = pin_sync[1];
  assign not_ready_flag = pin_sync[0];

  // Limits shadow nonvolatile storage; no write protection here
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hi_limit <= `LIMIT_RESET;
      lo_limit <= `LIMIT_RESET;
    end else if (wr_i) begin
      unique case (addr_i)
        `HI_WARN_LIMIT_ADDR: hi_limit[15:8] <= wdata_i;
        `HI_WARN_LIMIT_ADDR + 8'h01: hi_limit[7:0] <= wdata_i;
        `LO_WARN_LIMIT_ADDR: lo_limit[15:8] <= wdata_i;
        `LO_WARN_LIMIT_ADDR + 8'h01: lo_limit[7:0] <= wdata_i;
        default: ;
      endcase
    end
  end

  assign cal_idx = addr_i - `EXT_CAL_FIRST;

  generate
    for (genvar i = 0; i < CAL_BYTES; i++) begin : g_cal
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          cal_mem[i] <= `EXT_CAL_RESET;
        end else if (wr_i && addr_i >= `EXT_CAL_FIRST && addr_i <= `EXT_CAL_LAST
                     && cal_idx == 8'(i)) begin
          cal_mem[i] <= wdata_i;
        end
      end
    end
  endgenerate

  // A whole conversion set is taken in one edge so byte pairs never tear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      temp_res <= 16'h0000;
      vcc_res <= 16'h0000;
      first_monitor_input_res <= 16'h0000;
      second_monitor_input_res <= 16'h0000;
      third_monitor_input_res <= 16'h0000;
    end else if (conv_valid_i) begin
      temp_res <= conv_temp_i;
      vcc_res <= conv_vcc_i;
      first_monitor_input_res <= conv_first_monitor_input_i;
      second_monitor_input_res <= conv_second_monitor_input_i;
      third_monitor_input_res <= conv_third_monitor_input_i;
    end
  end

  // Flags follow the latest result; equal to a limit leaves the flag as it was
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      warn_hi <= 1'b0;
      warn_lo <= 1'b0;
    end else begin
      if (third_monitor_input_res > hi_limit) begin
        warn_hi <= 1'b1;
      end else if (third_monitor_input_res < hi_limit) begin
        warn_hi <= 1'b0;
      end
      if (third_monitor_input_res < lo_limit) begin
        warn_lo <= 1'b1;
      end else if (third_monitor_input_res > lo_limit) begin
        warn_lo <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      warn_flags_o <= 8'h00;
    end else begin
      warn_flags_o <= 8'h00;
      warn_flags_o[`WARN_HI_BIT] <= warn_hi;
      warn_flags_o[`WARN_LO_BIT] <= warn_lo;
    end
  end

  // Soft controls; other logic-state bits ignore writes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      soft_tx_disable <= 1'b0;
      soft_rate_select <= 1'b0;
    end else if (wr_i && addr_i == `LOGIC_STATES_ADDR) begin
      soft_tx_disable <= wdata_i[`LS_SOFT_TXD_BIT];
      soft_rate_select <= wdata_i[`LS_SOFT_RATE_SELECT_INPUT_PIN_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      current_sink_enable_o <= 1'b1;
      rate_select_output_pin_o <= 1'b0;
    end else begin
      current_sink_enable_o <= !soft_tx_disable;
      rate_select_output_pin_o <= rate_select_input_status | soft_rate_select;
    end
  end

  always_comb begin
    logic_states = 8'h00;
    logic_states[`LS_TXD_BIT] = tx_disable_pin_status;
    logic_states[`LS_SOFT_TXD_BIT] = soft_tx_disable;
    logic_states[`LS_GEN_IN_BIT] = general_input_status;
    logic_states[`LS_RATE_SELECT_INPUT_PIN_IN_BIT] = rate_select_input_status;
    logic_states[`LS_SOFT_RATE_SELECT_INPUT_PIN_BIT] = soft_rate_select;
    logic_states[`LS_TXF_BIT] = tx_fault_status;
    logic_states[`LS_RXLOS_BIT] = rx_signal_loss_status;
    logic_states[`LS_NRDY_BIT] = not_ready_flag;
  end

  // Reserved and unmapped bytes read zero
  always_comb begin
    next_rdata = `RSVD_READ;
    if (addr_i >= `EXT_CAL_FIRST && addr_i <= `EXT_CAL_LAST) begin
      next_rdata = cal_mem[cal_idx[5:0]];
    end else begin
      unique case (addr_i)
        `HI_WARN_LIMIT_ADDR: next_rdata = hi_limit[15:8];
        `HI_WARN_LIMIT_ADDR + 8'h01: next_rdata = hi_limit[7:0];
        `LO_WARN_LIMIT_ADDR: next_rdata = lo_limit[15:8];
        `LO_WARN_LIMIT_ADDR + 8'h01: next_rdata = lo_limit[7:0];
        `TEMP_ADDR: next_rdata = temp_res[15:8];
        `TEMP_ADDR + 8'h01: next_rdata = temp_res[7:0];
        `VCC_ADDR: next_rdata = vcc_res[15:8];
        `VCC_ADDR + 8'h01: next_rdata = vcc_res[7:0];
        `FIRST_MONITOR_INPUT_ADDR: next_rdata = first_monitor_input_res[15:8];
        `FIRST_MONITOR_INPUT_ADDR + 8'h01: next_rdata = first_monitor_input_res[7:0];
        `SECOND_MONITOR_INPUT_ADDR: next_rdata = second_monitor_input_res[15:8];
        `SECOND_MONITOR_INPUT_ADDR + 8'h01: next_rdata = second_monitor_input_res[7:0];
        `THIRD_MONITOR_INPUT_ADDR: next_rdata = third_monitor_input_res[15:8];
        `THIRD_MONITOR_INPUT_ADDR + 8'h01: next_rdata = third_monitor_input_res[7:0];
        `LOGIC_STATES_ADDR: next_rdata = logic_states;
        `WARN_FLAGS_ADDR: next_rdata = warn_flags_o;
        default: next_rdata = `RSVD_READ;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule

// ### design/monitor_limits_consts.svh
// Offsets, field positions, reset values and counts of the monitor limits block
`ifndef MONITOR_LIMITS_CONSTS_SVH
`define MONITOR_LIMITS_CONSTS_SVH
`define HI_WARN_LIMIT_ADDR 8'h24
`define LO_WARN_LIMIT_ADDR 8'h26
`define RSVD_A_FIRST 8'h28
`define RSVD_A_LAST 8'h37
`define EXT_CAL_FIRST 8'h38
`define EXT_CAL_LAST 8'h5F
`define EXT_CAL_BYTES 40
`define TEMP_ADDR 8'h60
`define VCC_ADDR 8'h62
`define FIRST_MONITOR_INPUT_ADDR 8'h64
`define SECOND_MONITOR_INPUT_ADDR 8'h66
`define THIRD_MONITOR_INPUT_ADDR 8'h68
`define RSVD_B_FIRST 8'h6A
`define RSVD_B_LAST 8'h6D
`define LOGIC_STATES_ADDR 8'h6E
`define RSVD_COMPANION_ADDR 8'h6F
`define WARN_FLAGS_ADDR 8'h75
`define WARN_HI_BIT 7
`define WARN_LO_BIT 6
`define LS_TXD_BIT 7
`define LS_SOFT_TXD_BIT 6
`define LS_GEN_IN_BIT 5
`define LS_RATE_SELECT_INPUT_PIN_IN_BIT 4
`define LS_SOFT_RATE_SELECT_INPUT_PIN_BIT 3
`define LS_TXF_BIT 2
`define LS_RXLOS_BIT 1
`define LS_NRDY_BIT 0
`define LIMIT_RESET 16'h0000
`define EXT_CAL_RESET 8'h00
`define RSVD_READ 8'h00
`endif

// ### design/monitor_limits_pkg.sv
// Types shared by the monitor limits block
package monitor_limits_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [15:0] word_t;
endpackage

// ### tb/host_bus_model.sv
// Host model driving the register port
`timescale 1ns/1ps
module host_bus_model (
  input wire logic clk_i,
  input wire monitor_limits_pkg::byte_t rdata_i,
  output logic [7:0] addr_o = 8'h00,
  output logic [7:0] wdata_o = 8'h00,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0
);
  import monitor_limits_pkg::*;
  // Address is inverted after each strobe so a stale value never passes
  task automatic wr_byte(input byte_t a, input byte_t d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
  endtask
  task automatic rd_byte(input byte_t a, output byte_t d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    // Read data stand for one cycle; take them mid-cycle, clear of the edge that launches them
    @(negedge clk_i);
    d = rdata_i;
  endtask
endmodule

// ### tb/monitor_limits_and_logic_states_tb_top.sv
// Self-checking testbench for the monitor limits block
`timescale 1ns/1ps
module monitor_limits_and_logic_states_tb_top;
  import monitor_limits_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cv = 1'b0;
  logic [5:0] pins = 6'h3F;
  word_t cw [5] = '{16'hF380, 16'h8124, 16'h0001, 16'hFFFE, 16'h0000};
  byte_t ta [11] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h38, 8'h5F, 8'h30, 8'h6A, 8'h6F, 8'h61, 8'h75};
  byte_t te [11] = '{8'h12, 8'h34, 8'h01, 8'h22, 8'hA5, 8'h5A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40};
  word_t mv [4] = '{16'h2000, 16'h0050, 16'h0800, 16'h1234};
  byte_t fe [4] = '{8'h80, 8'h40, 8'h00, 8'h00};
  logic [5:0] pv [2] = '{6'h2A, 6'h15};
  byte_t sv [4] = '{8'hFF, 8'h00, 8'h40, 8'h08};
  logic [7:0] addr, wdata;
  logic wr, rd, rso, cse;
  byte_t rdata, warn, got;
  int mismatches = 0;
  int checks = 0;
  always #10 clk_i = ~clk_i;
  host_bus_model i_host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));
  monitor_limits_and_logic_states #(.CAL_BYTES(40)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .conv_valid_i(cv),
    .conv_temp_i(cw[0]), .conv_vcc_i(cw[1]), .conv_first_monitor_input_i(cw[2]), .conv_second_monitor_input_i(cw[3]),
    .conv_third_monitor_input_i(cw[4]), .tx_disable_pin_i(pins[5]), .general_input_pin_i(pins[4]),
    .rate_select_input_pin_i(pins[3]), .tx_fault_pin_i(pins[2]), .rx_signal_loss_pin_i(pins[1]),
    .below_power_on_analog_threshold_i(pins[0]), .rate_select_output_pin_o(rso),
    .current_sink_enable_o(cse), .warn_flags_o(warn));
  task automatic chk(input byte_t g, input byte_t e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, g, e);
    end
  endtask
  task automatic rc(input byte_t a, input byte_t e);
    i_host.rd_byte(a, got);
    chk(got, e);
  endtask
  task automatic conv(input word_t m);
    @(posedge clk_i);
    cw[4] <= m;
    cv <= 1'b1;
    @(posedge clk_i);
    cv <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ta[i]) rc(ta[i], 8'h00);
    rc(8'h6E, 8'hB7);
    $display("defaults done");
    // Refused writes carry all ones so any leak shows
    foreach (ta[i]) i_host.wr_byte(ta[i], i < 6 ? te[i] : 8'hFF);
    foreach (ta[i]) rc(ta[i], te[i]);
    $display("limits done");
    foreach (mv[i]) begin
      conv(mv[i]);
      chk(warn, fe[i]);
      for (int k = 0; k < 5; k++) begin
        rc(8'h60 + 8'(2 * k), cw[k][15:8]);
        rc(8'h61 + 8'(2 * k), cw[k][7:0]);
      end
    end
    $display("results done");
    foreach (pv[i]) begin
      pins <= pv[i];
      repeat (3) @(posedge clk_i);
      rc(8'h6E, {pv[i][5], 1'b0, pv[i][4:3], 1'b0, pv[i][2:0]});
      chk({7'h00, rso}, {7'h00, pv[i][3]});
    end
    foreach (sv[i]) begin
      i_host.wr_byte(8'h6E, sv[i]);
      rc(8'h6E, {1'b0, sv[i][6], 2'b10, sv[i][3], 3'b101});
      chk({7'h00, cse}, {7'h00, ~sv[i][6]});
      chk({7'h00, rso}, {7'h00, sv[i][3]});
    end
    $display("logic states done");
    results();
  end
endmodule
bind monitor_limits_and_logic_states monitor_limits_props #(.CAL_BYTES(CAL_BYTES)) i_props (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .conv_valid_i(conv_valid_i), .conv_third_monitor_input_i(conv_third_monitor_input_i),
  .rate_select_input_pin_i(rate_select_input_pin_i),
  .rate_select_output_pin_o(rate_select_output_pin_o),
  .current_sink_enable_o(current_sink_enable_o), .warn_flags_o(warn_flags_o));

// ### tb/monitor_limits_props.sv
// Assertions on the monitor limits block ports
`timescale 1ns/1ps
module monitor_limits_props #(
  parameter int CAL_BYTES = 40
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire monitor_limits_pkg::byte_t rdata_o,
  input wire logic conv_valid_i,
  input wire logic [15:0] conv_third_monitor_input_i,
  input wire logic rate_select_input_pin_i,
  input wire logic rate_select_output_pin_o,
  input wire logic current_sink_enable_o,
  input wire monitor_limits_pkg::byte_t warn_flags_o
);
  import monitor_limits_pkg::*;
  word_t hi, lo, m3;
  logic txd, sr;
  logic [2:0] rs, qt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Mirrors of host writes, conversions and the rate-select pin, so no internal signal is needed
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {hi, lo, m3, txd, sr, rs, qt} <= '0;
    end else begin
      if (wr_i && addr_i == 8'h24) hi[15:8] <= wdata_i;
      if (wr_i && addr_i == 8'h25) hi[7:0] <= wdata_i;
      if (wr_i && addr_i == 8'h26) lo[15:8] <= wdata_i;
      if (wr_i && addr_i == 8'h27) lo[7:0] <= wdata_i;
      if (wr_i && addr_i == 8'h6E) {txd, sr} <= {wdata_i[6], wdata_i[3]};
      if (conv_valid_i) m3 <= conv_third_monitor_input_i;
      rs <= {rs[1:0], rate_select_input_pin_i};
      // Flags lag two edges; only a quiet spell gives a settled compare
      qt <= (wr_i || conv_valid_i) ? 3'h0 : (qt == 3'h3 ? qt : qt + 3'h1);
    end
  end
  warn_high_a: assert property (qt == 3'h3 && m3 != hi |-> warn_flags_o[7] == (m3 > hi))
    else $error("high flag wrong");
  warn_low_a: assert property (qt == 3'h3 && m3 != lo |-> warn_flags_o[6] == (m3 < lo))
    else $error("low flag wrong");
  limit_read_a: assert property ($past(rd_i) && $past(addr_i) == 8'h24
    |-> rdata_o == 8'($past(hi) >> 8)) else $error("limit read wrong");
  sink_off_a: assert property (current_sink_enable_o == !$past(txd))
    else $error("sink enable wrong");
  rate_or_a: assert property (rs == 3'h7 || rs == 3'h0
    |-> rate_select_output_pin_o == (rs[0] | $past(sr))) else $error("rate output wrong");
  soft_read_a: assert property ($past(rd_i) && $past(addr_i) == 8'h6E
    |-> rdata_o[6] == $past(txd) && rdata_o[3] == $past(sr)) else $error("soft bits wrong");
  rsvd_read_a: assert property ($past(rd_i) && $past(addr_i) inside
    {[8'h28:8'h37], [8'h6A:8'h6D], 8'h6F} |-> rdata_o == 8'h00) else $error("reserved read");
  third_monitor_input_read_a: assert property ($past(rd_i) && $past(addr_i) == 8'h69
    |-> rdata_o == 8'($past(m3))) else $error("result read wrong");
endmodule
